// ### core/tcv_map.vh
`ifndef TCV_MAP_VH
`define TCV_MAP_VH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define TCV_A_TSC 6'h00
`define TCV_A_CNT 6'h04
`define TCV_A_MOD 6'h08
`define TCV_A_CH0SC 6'h10
`define TCV_A_CH0VH 6'h14
`define TCV_A_CH0VL 6'h18
`define TCV_A_CH1SC 6'h20
`define TCV_A_CH1VH 6'h24
`define TCV_A_CH1VL 6'h28
`define TCV_A_CHSTEP 6'h10

// ----------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------
`define TCV_TSC_CLKS 1:0
`define TCV_TSC_PS 4:2
`define TCV_TSC_CENTER_ALIGNED_SELECT 5
`define TCV_TSC_OVERFLOW_INTERRUPT_ENABLE 6
`define TCV_TSC_TOF 7
`define TCV_CSC_MSA 4
`define TCV_CSC_MSB 5

// ----------------------------------------------------------------------
// Encodings and reset values
// ----------------------------------------------------------------------
`define TCV_CLK_OFF 2'h0
`define TCV_CLK_BUS 2'h1
`define TCV_CLK_FIX 2'h2
`define TCV_CLK_EXT 2'h3
`define TCV_W0 16'h0000
`define TCV_W1 16'h0001
`define TCV_WMAX 16'hffff
`define TCV_B0 8'h00
`define TCV_HTRANS_NONSEQ 2'h2
`define TCV_HTRANS_SEQ 2'h3

`endif

// ### core/tcv_timer.v
`timescale 1ns/100ps
`default_nettype none
`include "tcv_map.vh"

// Operation
// - Reset clears all channel value halves
// - Capture read freezes other half until read
// - Channel control write clears coherency sequence
// - Capture mode ignores value writes
// - Debug halt freezes read coherency state
// - Debug halt reads return live value
// - Compare/PWM writes buffered, moved as word
// - Clock off loads on second half
// - Compare mode loads on next count
// - PWM loads at modulus minus one step
// - Debug halt freezes write coherency state
// - Debug halt writes go straight through
// - Halt writes keep partial sequence intact
// - Center select forces center PWM updown
// - Clock select chooses prescaler input
// - Clock select resets off, keeps counter
// - External clock synchronized to bus clock
// - Overflow request is flag and enable
// - Free up count wraps, sets flag
// - Modulus wrap to zero sets flag
// - Center mode flag at top reversal
// - Mode bits select capture, compare, PWM
module tcv_timer (
    // AHB-Lite slave
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [1:0] htrans,
    input wire [31:0] haddr,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    // Timer side
    input wire debug_halt_mode,
    input wire fixed_clk_en,
    input wire ext_clk_pin,
    input wire [1:0] capture_event,
    output reg overflow_irq
);

// ----------------------------------------------------------------------
// Registers
// ----------------------------------------------------------------------
reg [1:0] clk_sel_ff;
reg [2:0] prescale_ff;
reg center_ff;
reg overflow_interrupt_enable_ff;
reg tof_ff;
reg [15:0] cnt_ff;
reg [15:0] mod_ff;
reg down_ff;
reg [7:0] ps_cnt_ff;
reg [2:0] ext_sync_ff;
reg [1:0] mode_ff [0:1];
reg [15:0] chv_ff [0:1];
reg [15:0] wbuf_ff [0:1];
reg [1:0] wgot_ff [0:1];
reg [1:0] wpend_ff;
reg [15:0] rbuf_ff [0:1];
reg [1:0] rlat_ff [0:1];
reg [1:0] evt_sync1_ff;
reg [1:0] evt_sync2_ff;
reg [1:0] evt_last_ff;
reg halt_s1_ff;
reg halt_ff;
reg tof_rd_ff;
reg ap_wr_ff;
reg ap_rd_ff;
reg [5:0] ap_addr_ff;

// ----------------------------------------------------------------------
// Clock source and prescaler
// ----------------------------------------------------------------------
wire ext_rise = ext_sync_ff[1] & ~ext_sync_ff[2];
reg src_en;
always @* begin
    case (clk_sel_ff)
        `TCV_CLK_BUS: src_en = 1'b1;
        `TCV_CLK_FIX: src_en = fixed_clk_en;
        `TCV_CLK_EXT: src_en = ext_rise;
        default: src_en = 1'b0;
    endcase
end
wire [7:0] ps_top = (8'h01 << prescale_ff) - 8'h01;
wire cnt_tick = src_en & (ps_cnt_ff == ps_top) & ~halt_ff;
wire [15:0] term = (mod_ff == `TCV_W0) ? `TCV_WMAX : mod_ff;
wire at_term = (cnt_ff == term);
wire pwm_step = cnt_tick & ~down_ff & (cnt_ff == term - `TCV_W1);

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        ext_sync_ff <= 3'h0;
        halt_s1_ff <= 1'b0;
        halt_ff <= 1'b0;
        evt_sync1_ff <= 2'h0;
        evt_sync2_ff <= 2'h0;
        evt_last_ff <= 2'h0;
    end else begin
        ext_sync_ff <= {ext_sync_ff[1:0], ext_clk_pin};
        halt_s1_ff <= debug_halt_mode;
        halt_ff <= halt_s1_ff;
        evt_sync1_ff <= capture_event;
        evt_sync2_ff <= evt_sync1_ff;
        evt_last_ff <= evt_sync2_ff;
    end
end

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        ps_cnt_ff <= `TCV_B0;
        cnt_ff <= `TCV_W0;
        down_ff <= 1'b0;
    end else if (src_en && !halt_ff) begin
        ps_cnt_ff <= cnt_tick ? `TCV_B0 : ps_cnt_ff + 8'h01;
        if (cnt_tick) begin
            if (center_ff) begin
                if (!down_ff && at_term) begin
                    down_ff <= 1'b1;
                    cnt_ff <= cnt_ff - `TCV_W1;
                end else if (down_ff && cnt_ff == `TCV_W1) begin
                    down_ff <= 1'b0;
                    cnt_ff <= `TCV_W0;
                end else begin
                    cnt_ff <= down_ff ? cnt_ff - `TCV_W1 : cnt_ff + `TCV_W1;
                end
            end else begin
                down_ff <= 1'b0;
                cnt_ff <= at_term ? `TCV_W0 : cnt_ff + `TCV_W1;
            end
        end
    end
end

// ----------------------------------------------------------------------
// Bus decode
// ----------------------------------------------------------------------
function [2:0] ch_dec; // {valid, channel, reg 0=sc 1=vh 2=vl ignored}
    input [5:0] a;
    begin
        ch_dec = {a[5:4] == 2'h1 || a[5:4] == 2'h2, a[5], 1'b0};
    end
endfunction

wire wr_now = ap_wr_ff;
wire [2:0] dec = ch_dec(ap_addr_ff);
wire ch_ok = dec[2];
wire chn = dec[1];
wire [5:0] ch_off = ap_addr_ff - (chn ? (`TCV_A_CH1SC) : (`TCV_A_CH0SC));
wire is_sc = ch_ok && ch_off == `TCV_A_CH0SC - `TCV_A_CHSTEP;
wire is_vh = ch_ok && ch_off == `TCV_A_CH0VH - `TCV_A_CHSTEP;
wire is_vl = ch_ok && ch_off == `TCV_A_CH0VL - `TCV_A_CHSTEP;
wire take = hsel & hready & (htrans == `TCV_HTRANS_NONSEQ || htrans == `TCV_HTRANS_SEQ);

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        ap_wr_ff <= 1'b0;
        ap_rd_ff <= 1'b0;
        ap_addr_ff <= 6'h00;
        hreadyout <= 1'b1;
        hresp <= 1'b0;
    end else begin
        ap_wr_ff <= take & hwrite;
        ap_rd_ff <= take & ~hwrite;
        if (take)
            ap_addr_ff <= {haddr[5:2], 2'h0};
        hreadyout <= 1'b1;
        hresp <= 1'b0;
    end
end

// Read data is registered at the address phase, ready in the data phase
reg [31:0] rd_mux;
wire rd_take = take & ~hwrite;
wire [5:0] ra = {haddr[5:2], 2'h0};
wire [2:0] rdec = ch_dec(ra);
wire rch = rdec[1];
wire [5:0] r_off = ra - (rch ? (`TCV_A_CH1SC) : (`TCV_A_CH0SC));
wire r_vh = rdec[2] && r_off == `TCV_A_CH0VH - `TCV_A_CHSTEP;
wire r_vl = rdec[2] && r_off == `TCV_A_CH0VL - `TCV_A_CHSTEP;
wire r_cap = rdec[2] && !center_ff && mode_ff[rch] == 2'h0;
always @* begin
    rd_mux = 32'h0000_0000;
    if (ra == `TCV_A_TSC)
        rd_mux[7:0] = {tof_ff, overflow_interrupt_enable_ff, center_ff, prescale_ff, clk_sel_ff};
    else if (ra == `TCV_A_CNT)
        rd_mux[15:0] = cnt_ff;
    else if (ra == `TCV_A_MOD)
        rd_mux[15:0] = mod_ff;
    else if (rdec[2] && r_off == `TCV_A_CH0SC - `TCV_A_CHSTEP)
        rd_mux[7:0] = {2'h0, mode_ff[rch], 4'h0};
    else if (r_vh)
        rd_mux[7:0] = (r_cap && !halt_ff && rlat_ff[rch][1]) ?
            rbuf_ff[rch][15:8] : chv_ff[rch][15:8];
    else if (r_vl)
        rd_mux[7:0] = (r_cap && !halt_ff && rlat_ff[rch][0]) ?
            rbuf_ff[rch][7:0] : chv_ff[rch][7:0];
end

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        hrdata <= 32'h0000_0000;
        tof_rd_ff <= 1'b0;
    end else begin
        if (rd_take)
            hrdata <= rd_mux;
        if (rd_take && ra == `TCV_A_TSC)
            tof_rd_ff <= tof_ff;
    end
end

// ----------------------------------------------------------------------
// Timer control and overflow
// ----------------------------------------------------------------------
wire tof_set = cnt_tick & (center_ff ? (~down_ff & at_term) : at_term);
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        clk_sel_ff <= `TCV_CLK_OFF;
        prescale_ff <= 3'h0;
        center_ff <= 1'b0;
        overflow_interrupt_enable_ff <= 1'b0;
        tof_ff <= 1'b0;
        mod_ff <= `TCV_W0;
        overflow_irq <= 1'b0;
    end else begin
        if (wr_now && ap_addr_ff == `TCV_A_TSC) begin
            clk_sel_ff <= hwdata[`TCV_TSC_CLKS];
            prescale_ff <= hwdata[`TCV_TSC_PS];
            center_ff <= hwdata[`TCV_TSC_CENTER_ALIGNED_SELECT];
            overflow_interrupt_enable_ff <= hwdata[`TCV_TSC_OVERFLOW_INTERRUPT_ENABLE];
        end
        if (wr_now && ap_addr_ff == `TCV_A_MOD)
            mod_ff <= hwdata[15:0];
        // Set wins over a clear in the same cycle
        if (tof_set)
            tof_ff <= 1'b1;
        else if (wr_now && ap_addr_ff == `TCV_A_TSC && tof_rd_ff && !hwdata[`TCV_TSC_TOF])
            tof_ff <= 1'b0;
        overflow_irq <= (tof_ff | tof_set) & overflow_interrupt_enable_ff;
    end
end

// ----------------------------------------------------------------------
// Channels
// ----------------------------------------------------------------------
genvar g;
generate
    for (g = 0; g < 2; g = g + 1) begin : g_ch
        wire sel = ch_ok && chn == g;
        wire capm = !center_ff && mode_ff[g] == 2'h0;
        wire edge_aligned_pwm = !center_ff && mode_ff[g][1];
        wire pwm = center_ff | edge_aligned_pwm;
        wire w_sc = wr_now && sel && is_sc;
        wire w_h = wr_now && sel && is_vh && !capm;
        wire w_l = wr_now && sel && is_vl && !capm;
        wire r_h = rd_take && rdec[2] && rch == g && r_vh && r_cap;
        wire r_l = rd_take && rdec[2] && rch == g && r_vl && r_cap;
        wire [1:0] got = wgot_ff[g] | {w_h, w_l};
        wire done = !halt_ff && got == 2'h3;
        wire load = wpend_ff[g] && (clk_sel_ff == `TCV_CLK_OFF ||
            (pwm ? pwm_step : cnt_tick));
        wire cap_hit = capm && evt_sync2_ff[g] && !evt_last_ff[g];

        always @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                mode_ff[g] <= 2'h0;
                chv_ff[g] <= `TCV_W0;
                wbuf_ff[g] <= `TCV_W0;
                wgot_ff[g] <= 2'h0;
                wpend_ff[g] <= 1'b0;
                rbuf_ff[g] <= `TCV_W0;
                rlat_ff[g] <= 2'h0;
            end else begin
                if (w_sc) begin
                    mode_ff[g] <= {hwdata[`TCV_CSC_MSB], hwdata[`TCV_CSC_MSA]};
                    wgot_ff[g] <= 2'h0;
                    rlat_ff[g] <= 2'h0;
                    wpend_ff[g] <= 1'b0;
                end else if (halt_ff) begin
                    if (w_h)
                        chv_ff[g][15:8] <= hwdata[7:0];
                    if (w_l)
                        chv_ff[g][7:0] <= hwdata[7:0];
                end else begin
                    if (w_h)
                        wbuf_ff[g][15:8] <= hwdata[7:0];
                    if (w_l)
                        wbuf_ff[g][7:0] <= hwdata[7:0];
                    if (done) begin
                        wgot_ff[g] <= 2'h0;
                        wpend_ff[g] <= 1'b1;
                    end else begin
                        wgot_ff[g] <= got;
                    end
                    if (r_h || r_l) begin
                        if (rlat_ff[g] == 2'h0) begin
                            rbuf_ff[g] <= chv_ff[g];
                            rlat_ff[g] <= r_h ? 2'h1 : 2'h2;
                        end else begin
                            rlat_ff[g] <= 2'h0;
                        end
                    end
                    // Immediate load needs the just-written half, so take it from the bus
                    if (done && clk_sel_ff == `TCV_CLK_OFF) begin
                        chv_ff[g] <= {w_h ? hwdata[7:0] : wbuf_ff[g][15:8],
                            w_l ? hwdata[7:0] : wbuf_ff[g][7:0]};
                        wpend_ff[g] <= 1'b0;
                    end else if (load && !done) begin
                        chv_ff[g] <= wbuf_ff[g];
                        wpend_ff[g] <= 1'b0;
                    end
                end
                if (cap_hit && !w_sc)
                    chv_ff[g] <= cnt_ff;
            end
        end
    end
endgenerate

endmodule // tcv_timer
`default_nettype wire

// ### testbench/tcv_host.sv
`timescale 1ns/100ps
`default_nettype none
module tcv_host (
    // Bus
    input wire logic hclk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [1:0] htrans,
    output logic [31:0] haddr,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    initial begin
        {hsel, htrans, haddr, hwrite, hsize, hwdata} = 71'h0;
    end

    // Single word; no cycle count assumed, the bench watchdog ends a hang
    task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= 32'(a);
        hwrite <= w;
        hsize <= 3'h2;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
    endtask
endmodule // tcv_host
`default_nettype wire

// ### testbench/tcv_timer_chk.sv
`timescale 1ns/100ps
`default_nettype none
module tcv_timer_chk (
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // Bus
    input wire hsel,
    input wire [1:0] htrans,
    input wire [31:0] haddr,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    // Timer
    input wire overflow_irq
);
    logic rd_ff, wr_ff, en_ff, en_q_ff, seen_ff;
    logic [3:0] a_ff;
    wire take = hsel && hready && htrans[1];
    wire tsc_wr = wr_ff && (a_ff == 4'h0);
    wire mapped = (a_ff[3:2] != 2'h3) && (a_ff[1:0] != 2'h3);
    wire val = (a_ff[3:2] != 2'h0) && (a_ff[1:0] != 2'h0) && mapped;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {rd_ff, wr_ff, en_ff, en_q_ff, seen_ff} <= 5'h00;
            a_ff <= 4'h0;
        end else begin
            rd_ff <= take && !hwrite;
            wr_ff <= take && hwrite;
            a_ff <= take ? haddr[5:2] : a_ff;
            en_ff <= tsc_wr ? hwdata[6] : en_ff;
            seen_ff <= seen_ff || tsc_wr;
            en_q_ff <= en_ff;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_ready; hreadyout; endproperty
    property p_okay; !hresp; endproperty
    property p_unmap; rd_ff && !mapped |-> hrdata == 32'h0000_0000; endproperty
    property p_byte; rd_ff && val |-> hrdata[31:8] == 24'h00_0000; endproperty
    property p_hold; !rd_ff |-> $stable(hrdata); endproperty
    property p_rst; rd_ff && a_ff == 4'h0 && !seen_ff |-> hrdata[6:0] == 7'h00; endproperty
    property p_fall; $fell(overflow_irq) |-> $past(tsc_wr, 1) || $past(tsc_wr, 2); endproperty
    property p_off; !en_ff && !en_q_ff |-> !overflow_irq; endproperty

    a_ready: assert property (p_ready) else $error("wait state seen");
    a_okay: assert property (p_okay) else $error("error response seen");
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    a_byte: assert property (p_byte) else $error("value half wider than a byte");
    a_hold: assert property (p_hold) else $error("read data moved without a read");
    a_rst: assert property (p_rst) else $error("control not at reset value");
    a_fall: assert property (p_fall) else $error("overflow request dropped alone");
    a_off: assert property (p_off) else $error("request while disabled");

    c_irq: cover property ($rose(overflow_irq));
    c_unmap: cover property (rd_ff && !mapped);
    c_tscw: cover property (tsc_wr);
endmodule // tcv_timer_chk

bind tcv_timer tcv_timer_chk i_chk (.hclk, .hresetn, .hsel, .htrans, .haddr, .hwrite,
    .hwdata, .hready, .hrdata, .hreadyout, .hresp, .overflow_irq);
`default_nettype wire

// ### testbench/timer_channel_value_and_counter_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "tcv_map.vh"
module timer_channel_value_and_counter_bench;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic debug_halt_mode = 1'b0;
    logic fixed_clk_en = 1'b0;
    logic ext_clk_pin = 1'b0;
    logic [1:0] capture_event = 2'h0;
    wire hsel, hwrite, hreadyout, hresp, overflow_irq;
    wire [1:0] htrans;
    wire [2:0] hsize;
    wire [31:0] haddr, hwdata, hrdata;
    int failures = 0;
    int n_checks = 0;
    logic [31:0] q;

    always #5 hclk = ~hclk;

    tcv_timer i_dut (.hclk, .hresetn, .hsel, .htrans, .haddr, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .debug_halt_mode, .fixed_clk_en,
        .ext_clk_pin, .capture_event, .overflow_irq);
    tcv_host i_host (.hclk, .hready(hreadyout), .hrdata, .hsel, .htrans, .haddr, .hwrite,
        .hsize, .hwdata);

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        i_host.xfer(1'b1, a, {16'h0000, d}, q);
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        i_host.xfer(1'b0, a, 32'h0000_0000, q);
        chk(q, {24'h00_0000, e});
    endtask
    task automatic cap();
        capture_event <= 2'h1;
        cyc(4);
        capture_event <= 2'h0;
        cyc(6);
    endtask
    // Counter stopped around each capture so captured values are fixed
    task automatic run(input int n);
        wr(`TCV_A_TSC, 16'h0001);
        cyc(n);
        wr(`TCV_A_TSC, 16'h0000);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        rd(`TCV_A_CH0VH, 8'h00);
        rd(`TCV_A_CH0VL, 8'h00);
        rd(`TCV_A_CH1VH, 8'h00);
        rd(`TCV_A_CH1VL, 8'h00);
        rd(`TCV_A_TSC, 8'h00);
        wr(6'h30, 16'h00ff);
        rd(6'h30, 8'h00);
        $display("reset test done");
    endtask
    task automatic t_direct();
        wr(`TCV_A_CH0SC, 16'h0010);
        wr(`TCV_A_CH0VH, 16'h0012);
        rd(`TCV_A_CH0VH, 8'h00);
        wr(`TCV_A_CH0VL, 16'h0034);
        rd(`TCV_A_CH0VH, 8'h12);
        rd(`TCV_A_CH0VL, 8'h34);
        wr(`TCV_A_CH1SC, 16'h0020);
        wr(`TCV_A_CH1VL, 16'h0078);
        rd(`TCV_A_CH1VL, 8'h00);
        wr(`TCV_A_CH1VH, 16'h0056);
        rd(`TCV_A_CH1VH, 8'h56);
        rd(`TCV_A_CH1VL, 8'h78);
        $display("direct load test done");
    endtask
    task automatic t_capture();
        wr(`TCV_A_CH0SC, 16'h0000);
        wr(`TCV_A_CH0VH, 16'h0099);
        rd(`TCV_A_CH0VH, 8'h12);
        rd(`TCV_A_CH0VL, 8'h34);
        cap();
        rd(`TCV_A_CH0VL, 8'h00);
        run(300);
        cap();
        rd(`TCV_A_CH0VH, 8'h00);
        i_host.xfer(1'b0, `TCV_A_CH0VL, 32'h0000_0000, q);
        wr(`TCV_A_CH0SC, 16'h0000);
        run(300);
        cap();
        rd(`TCV_A_CH0VH, 8'h02);
        $display("capture test done");
    endtask
    task automatic t_halt();
        wr(`TCV_A_CH0SC, 16'h0010);
        wr(`TCV_A_CH0VH, 16'h00aa);
        debug_halt_mode <= 1'b1;
        cyc(4);
        wr(`TCV_A_CH0VL, 16'h0077);
        rd(`TCV_A_CH0VL, 8'h77);
        rd(`TCV_A_CH0VH, 8'h02);
        debug_halt_mode <= 1'b0;
        cyc(4);
        wr(`TCV_A_CH0VL, 16'h0033);
        rd(`TCV_A_CH0VH, 8'haa);
        rd(`TCV_A_CH0VL, 8'h33);
        $display("halt test done");
    endtask
    task automatic t_tick();
        wr(`TCV_A_TSC, 16'h0002);
        wr(`TCV_A_CH0VH, 16'h000f);
        wr(`TCV_A_CH0VL, 16'h00f0);
        rd(`TCV_A_CH0VH, 8'haa);
        fixed_clk_en <= 1'b1;
        cyc(4);
        fixed_clk_en <= 1'b0;
        cyc(2);
        rd(`TCV_A_CH0VH, 8'h0f);
        rd(`TCV_A_CH0VL, 8'hf0);
        rd(`TCV_A_TSC, 8'h02);
        $display("tick load test done");
    endtask
    task automatic t_ovf();
        wr(`TCV_A_MOD, 16'h0300);
        wr(`TCV_A_TSC, 16'h0041);
        for (int i = 0; i < 400 && overflow_irq !== 1'b1; i++) @(posedge hclk);
        chk({31'h0000_0000, overflow_irq}, 32'h0000_0001);
        wr(`TCV_A_TSC, 16'h0080);
        cyc(3);
        chk({31'h0000_0000, overflow_irq}, 32'h0000_0000);
        rd(`TCV_A_TSC, 8'h80);
        wr(`TCV_A_TSC, 16'h0000);
        rd(`TCV_A_TSC, 8'h00);
        $display("overflow test done");
    endtask
    // Pin clock kept at an eighth of the bus rate, well inside the limit
    task automatic t_ext();
        logic [31:0] c0;
        i_host.xfer(1'b0, `TCV_A_CNT, 32'h0000_0000, c0);
        wr(`TCV_A_TSC, 16'h0003);
        for (int i = 0; i < 8; i++) begin
            ext_clk_pin <= 1'b1;
            cyc(4);
            ext_clk_pin <= 1'b0;
            cyc(4);
        end
        wr(`TCV_A_TSC, 16'h0000);
        i_host.xfer(1'b0, `TCV_A_CNT, 32'h0000_0000, q);
        chk(q, c0 + 32'h0000_0008);
        $display("external clock test done");
    endtask

    task automatic final_report();
        $display("checks %0d, failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        cyc(16);
        hresetn <= 1'b1;
        cyc(1);
        t_reset();
        t_direct();
        t_capture();
        t_halt();
        t_tick();
        t_ovf();
        t_ext();
        final_report();
    end
    // Tests need about 1000 cycles
    initial begin
        #50000;
        failures++;
        $display("Error at %0t: watchdog expired", $time);
        final_report();
    end
endmodule // timer_channel_value_and_counter_bench
`default_nettype wire
